/* dclsc_cfg.svh */
// register offsets, field positions and reset values of the line state control
`ifndef DCLSC_CFG_SVH
`define DCLSC_CFG_SVH
`define DCLSC_REG_CTRL 8'h00
`define DCLSC_REG_STATUS 8'h04
`define DCLSC_REG_LINE_SEL 8'h08
`define DCLSC_REG_LINE_STATE 8'h0C
`define DCLSC_REG_WT_COUNT 8'h10
`define DCLSC_CTRL_IGNORE_BIT 0
`define DCLSC_CTRL_RST 1'h0
`define DCLSC_CNT_W 16
`define DCLSC_LINE_BEATS 4
`define DCLSC_NUM_LINES 8
`define DCLSC_PIN_POL 2
`define DCLSC_PIN_NA 1
`define DCLSC_PIN_BURST_READY 0
`define DCLSC_PIN_RST 3'h3
`endif

/* dclsc_pkg.sv */
// types shared by the line state control files
package dclsc_pkg;
    typedef enum logic [1:0] {
        DCLSC_I = 2'h0,
        DCLSC_S = 2'h1,
        DCLSC_E = 2'h2,
        DCLSC_M = 2'h3
    } dclsc_mesi_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FILL = 3'h1,
        ST_WTHRU = 3'h3,
        ST_WBACK = 3'h2
    } dclsc_fsm_t;
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_REPLACE = 2'h2,
        OP_INQUIRY = 2'h3
    } dclsc_op_t;
    typedef enum logic [1:0] {
        BUS_NONE = 2'h0,
        BUS_FILL = 2'h1,
        BUS_WRITE = 2'h2,
        BUS_WBACK = 2'h3
    } dclsc_bus_t;
endpackage

/* dclsc_pin_sync.sv */
// three-stage pin synchroniser, level moves once stages two and three agree
`timescale 1ns/1ns
module dclsc_pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } dclsc_sync_t;

    dclsc_sync_t sync_reg;
    dclsc_sync_t sync_next;

    if (WIDTH < 1) begin : g_chk
        $error("dclsc_pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = pin_i;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        // s1 feeds only s2; a bit whose late stages differ holds its old level
        sync_next.lvl = (sync_reg.lvl & (sync_reg.s2 ^ sync_reg.s3))
            | (sync_reg.s2 & ~(sync_reg.s2 ^ sync_reg.s3));
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync_reg <= {4{RST_VAL}};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level_o = sync_reg.lvl;
endmodule

/* dclsc_line_state.sv */
// per-line coherence state keeper with bus sequencing and register port
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`include "dclsc_cfg.svh"
module dclsc_line_state #(
    parameter int NUM_LINES = `DCLSC_NUM_LINES,
    parameter int LINE_BEATS = `DCLSC_LINE_BEATS,
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire dclsc_pkg::dclsc_op_t op_kind_i,
    input wire logic [$clog2(NUM_LINES)-1:0] op_line_i,
    input wire logic inquiry_invalidate_i,
    input wire logic page_write_through_bit_i,
    output logic op_ready_o,
    output logic op_done_o,
    input wire logic policy_select_pin_i,
    input wire logic next_address_request_n_i,
    input wire logic burst_ready_n_i,
    output logic bus_req_o,
    output dclsc_pkg::dclsc_bus_t bus_kind_o,
    output logic [$clog2(NUM_LINES)-1:0] bus_line_o,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import dclsc_pkg::*;

    localparam int IDX_W = $clog2(NUM_LINES);
    localparam int BEAT_W = $clog2(LINE_BEATS + 1);

    if (NUM_LINES < 2 || LINE_BEATS < 1 || ADDR_W < 8) begin : g_chk
        $error("dclsc_line_state: unsupported parameter values");
    end

    typedef struct packed {
        dclsc_fsm_t fsm;
        dclsc_mesi_t [NUM_LINES-1:0] lines;
        logic [IDX_W-1:0] cur;
        dclsc_mesi_t result;
        logic wt;
        logic sampled;
        logic [BEAT_W-1:0] beats;
        logic bus_req;
        dclsc_bus_t bus_kind;
        logic ready;
        logic done;
        logic ignore_pin;
        logic [IDX_W-1:0] sel;
        logic [`DCLSC_CNT_W-1:0] wt_cnt;
        logic [31:0] rdata;
    } dclsc_state_t;

    dclsc_state_t st_reg;
    dclsc_state_t st_next;
    dclsc_state_t st_rst;

    logic [2:0] pin_lvl;
    logic pol_high;
    logic na_act;
    logic burst_ready_act;
    logic pol_eff;
    logic last_beat;
    logic accept;
    dclsc_mesi_t cur_ls;

    dclsc_pin_sync #(
        .WIDTH(3),
        .RST_VAL(`DCLSC_PIN_RST)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i({policy_select_pin_i, next_address_request_n_i, burst_ready_n_i}),
        .level_o(pin_lvl)
    );

    assign pol_high = pin_lvl[`DCLSC_PIN_POL];
    assign na_act = !pin_lvl[`DCLSC_PIN_NA];
    assign burst_ready_act = !pin_lvl[`DCLSC_PIN_BURST_READY];
    // page bit and software override both force the write-through reading
    assign pol_eff = pol_high && !st_reg.wt && !st_reg.ignore_pin;
    assign last_beat = st_reg.beats == BEAT_W'(LINE_BEATS - 1);
    assign accept = op_valid_i && st_reg.ready;
    assign cur_ls = st_reg.lines[op_line_i];

    always_comb begin
        st_rst = '0;
        st_rst.fsm = ST_IDLE;
        st_rst.lines = {NUM_LINES{DCLSC_I}};
        st_rst.result = DCLSC_I;
        st_rst.bus_kind = BUS_NONE;
        st_rst.ready = 1'b1;
        st_rst.ignore_pin = `DCLSC_CTRL_RST;
    end

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.rdata = '0;
        case (st_reg.fsm)
            ST_IDLE: begin
                if (accept) begin
                    st_next.cur = op_line_i;
                    st_next.wt = page_write_through_bit_i;
                    st_next.sampled = 1'b0;
                    st_next.beats = '0;
                    st_next.done = 1'b1;
                    case (op_kind_i)
                        OP_READ: begin
                            if (cur_ls == DCLSC_I) begin
                                st_next.fsm = ST_FILL;
                                st_next.bus_kind = BUS_FILL;
                            end
                            // hit: state left alone
                        end
                        OP_WRITE: begin
                            case (cur_ls)
                                DCLSC_E: begin
                                    if (page_write_through_bit_i) begin
                                        st_next.fsm = ST_WTHRU;
                                    end else begin
                                        st_next.lines[op_line_i] = DCLSC_M;
                                    end
                                end
                                DCLSC_M: begin
                                    if (page_write_through_bit_i) begin
                                        st_next.fsm = ST_WTHRU;
                                    end
                                end
                                default: begin
                                    // shared lines and misses go to the bus
                                    st_next.fsm = ST_WTHRU;
                                end
                            endcase
                            st_next.result = cur_ls;
                            st_next.bus_kind = st_next.fsm == ST_WTHRU ? BUS_WRITE : BUS_NONE;
                        end
                        OP_REPLACE: begin
                            if (cur_ls == DCLSC_M) begin
                                st_next.fsm = ST_WBACK;
                                st_next.bus_kind = BUS_WBACK;
                            end
                            st_next.result = DCLSC_I;
                            if (cur_ls != DCLSC_M) begin
                                st_next.lines[op_line_i] = DCLSC_I;
                            end
                        end
                        default: begin
                            st_next.result = inquiry_invalidate_i ? DCLSC_I : DCLSC_S;
                            if (cur_ls == DCLSC_M) begin
                                st_next.fsm = ST_WBACK;
                                st_next.bus_kind = BUS_WBACK;
                            end else if (cur_ls != DCLSC_I) begin
                                st_next.lines[op_line_i] = st_next.result;
                            end
                        end
                    endcase
                    if (st_next.fsm != ST_IDLE) begin
                        st_next.done = 1'b0;
                        st_next.ready = 1'b0;
                        st_next.bus_req = 1'b1;
                    end
                end
            end
            ST_FILL: begin
                if (!st_reg.sampled && (na_act || burst_ready_act)) begin
                    st_next.sampled = 1'b1;
                    // fill never lands in Modified
                    st_next.lines[st_reg.cur] = pol_eff ? DCLSC_E : DCLSC_S;
                end
                if (burst_ready_act) begin
                    st_next.beats = st_reg.beats + BEAT_W'(1);
                    if (last_beat) begin
                        st_next.fsm = ST_IDLE;
                        st_next.bus_req = 1'b0;
                        st_next.bus_kind = BUS_NONE;
                        st_next.ready = 1'b1;
                        st_next.done = 1'b1;
                    end
                end
            end
            ST_WTHRU: begin
                if (burst_ready_act) begin
                    // pin taken at the single data beat
                    if (st_reg.result == DCLSC_S && pol_eff) begin
                        st_next.lines[st_reg.cur] = DCLSC_E;
                    end else begin
                        st_next.lines[st_reg.cur] = st_reg.result;
                    end
                    st_next.wt_cnt = st_reg.wt_cnt + `DCLSC_CNT_W'(1);
                    st_next.fsm = ST_IDLE;
                    st_next.bus_req = 1'b0;
                    st_next.bus_kind = BUS_NONE;
                    st_next.ready = 1'b1;
                    st_next.done = 1'b1;
                end
            end
            ST_WBACK: begin
                if (burst_ready_act) begin
                    st_next.beats = st_reg.beats + BEAT_W'(1);
                    if (last_beat) begin
                        // state drops only after the whole line is out
                        st_next.lines[st_reg.cur] = st_reg.result;
                        st_next.fsm = ST_IDLE;
                        st_next.bus_req = 1'b0;
                        st_next.bus_kind = BUS_NONE;
                        st_next.ready = 1'b1;
                        st_next.done = 1'b1;
                    end
                end
            end
            default: begin
                st_next = st_rst;
            end
        endcase

        if (reg_wr_i) begin
            case (reg_addr_i[7:0])
                `DCLSC_REG_CTRL: begin
                    st_next.ignore_pin = reg_wdata_i[`DCLSC_CTRL_IGNORE_BIT];
                end
                `DCLSC_REG_LINE_SEL: begin
                    st_next.sel = reg_wdata_i[IDX_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i[7:0])
                `DCLSC_REG_CTRL: begin
                    st_next.rdata = 32'(st_reg.ignore_pin);
                end
                `DCLSC_REG_STATUS: begin
                    st_next.rdata = 32'({st_reg.bus_kind, st_reg.bus_req, st_reg.fsm});
                end
                `DCLSC_REG_LINE_SEL: begin
                    st_next.rdata = 32'(st_reg.sel);
                end
                `DCLSC_REG_LINE_STATE: begin
                    st_next.rdata = 32'(st_reg.lines[st_reg.sel]);
                end
                `DCLSC_REG_WT_COUNT: begin
                    st_next.rdata = 32'(st_reg.wt_cnt);
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end
        if (reg_addr_i[1:0] != 2'h0) begin
            // unaligned addresses read zero, writes are dropped
            st_next.rdata = '0;
            st_next.ignore_pin = st_reg.ignore_pin;
            st_next.sel = st_reg.sel;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg <= st_rst;
        end else begin
            st_reg <= st_next;
        end
    end

    assign op_ready_o = st_reg.ready;
    assign op_done_o = st_reg.done;
    assign bus_req_o = st_reg.bus_req;
    assign bus_kind_o = st_reg.bus_kind;
    assign bus_line_o = st_reg.cur;
    assign reg_rdata_o = st_reg.rdata;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_fill_sample;
        st_reg.fsm == ST_FILL && !st_reg.sampled && (na_act || burst_ready_act)
            |=> st_reg.lines[st_reg.cur] == ($past(pol_eff) ? DCLSC_E : DCLSC_S);
    endproperty
    a_fill_sample: assert property (p_fill_sample) else $error("fill state wrong");

    property p_fill_not_mod;
        st_reg.fsm == ST_FILL && burst_ready_act && last_beat
            |=> op_done_o && st_reg.lines[st_reg.cur] != DCLSC_M && st_reg.lines[st_reg.cur] != DCLSC_I;
    endproperty
    a_fill_not_mod: assert property (p_fill_not_mod) else $error("fill ended badly");

    property p_read_hit;
        accept && op_kind_i == OP_READ && cur_ls != DCLSC_I
            |=> op_done_o && !bus_req_o && st_reg.lines[st_reg.cur] == $past(cur_ls);
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("read hit changed line");

    property p_excl_write;
        accept && op_kind_i == OP_WRITE && cur_ls == DCLSC_E && !page_write_through_bit_i
            |=> !bus_req_o && st_reg.lines[st_reg.cur] == DCLSC_M;
    endproperty
    a_excl_write: assert property (p_excl_write) else $error("exclusive write wrong");

    property p_write_out;
        accept && op_kind_i == OP_WRITE && (cur_ls == DCLSC_I || cur_ls == DCLSC_S
            || page_write_through_bit_i)
            |=> bus_req_o && bus_kind_o == BUS_WRITE;
    endproperty
    a_write_out: assert property (p_write_out) else $error("write not on bus");

    property p_shared_write;
        st_reg.fsm == ST_WTHRU && burst_ready_act && st_reg.result == DCLSC_S
            |=> !bus_req_o ##0 st_reg.lines[st_reg.cur] == ($past(pol_eff) ? DCLSC_E : DCLSC_S);
    endproperty
    a_shared_write: assert property (p_shared_write) else $error("shared write wrong");

    property p_wt_page;
        st_reg.fsm == ST_WTHRU && st_reg.wt && burst_ready_act |=> st_reg.lines[st_reg.cur] != DCLSC_E
            || $past(st_reg.result) == DCLSC_E;
    endproperty
    a_wt_page: assert property (p_wt_page) else $error("page bit ignored");

    property p_write_miss;
        accept && op_kind_i == OP_WRITE && cur_ls == DCLSC_I
            |=> bus_req_o && st_reg.lines[st_reg.cur] == DCLSC_I;
    endproperty
    a_write_miss: assert property (p_write_miss) else $error("write miss wrong");

    property p_replace;
        accept && op_kind_i == OP_REPLACE && cur_ls == DCLSC_M
            |=> bus_kind_o == BUS_WBACK && st_reg.lines[st_reg.cur] == DCLSC_M;
    endproperty
    a_replace: assert property (p_replace) else $error("replace did not write back");

    property p_inq_share;
        accept && op_kind_i == OP_INQUIRY && !inquiry_invalidate_i && cur_ls == DCLSC_E
            |=> st_reg.lines[st_reg.cur] == DCLSC_S && !bus_req_o;
    endproperty
    a_inq_share: assert property (p_inq_share) else $error("inquiry share wrong");

    property p_inq_inv;
        accept && op_kind_i == OP_INQUIRY && inquiry_invalidate_i && cur_ls == DCLSC_S
            |=> st_reg.lines[st_reg.cur] == DCLSC_I;
    endproperty
    a_inq_inv: assert property (p_inq_inv) else $error("inquiry invalidate wrong");

    property p_kind_idle;
        !bus_req_o |-> bus_kind_o == BUS_NONE;
    endproperty
    a_kind_idle: assert property (p_kind_idle) else $error("bus kind shown while idle");
endmodule

/* dclsc_bus_agent.sv */
// behavioural bus agent that answers the line state control's bus cycles
`timescale 1ns/1ns
`include "dclsc_cfg.svh"
module dclsc_bus_agent (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic bus_req_i,
    input wire dclsc_pkg::dclsc_bus_t bus_kind_i,
    input wire logic pol_i,
    input wire logic write_once_i,
    input wire logic [3:0] delay_i,
    output logic policy_select_pin_o,
    output logic next_address_request_n_o,
    output logic burst_ready_n_o
);
    import dclsc_pkg::*;
    dclsc_bus_t kind;
    initial begin
        policy_select_pin_o = 1'b0;
        next_address_request_n_o = 1'b1;
        burst_ready_n_o = 1'b1;
    end
    always begin
        @(posedge clk_sys_i);
        if (rst_n_i === 1'b1 && bus_req_i === 1'b1) begin
            kind = bus_kind_i;
            repeat (delay_i) @(posedge clk_sys_i);
            // write-once wiring: the pin is high on BUS_WRITE cycles only, low on fills and write-backs
            policy_select_pin_o <= write_once_i ? (kind == BUS_WRITE) : pol_i;
            next_address_request_n_o <= (kind != BUS_FILL);
            burst_ready_n_o <= 1'b0;
            // a lone low cycle never passes the synchroniser, so a write beat is held two
            repeat ((kind == BUS_WRITE) ? 2 : `DCLSC_LINE_BEATS) @(posedge clk_sys_i);
            next_address_request_n_o <= 1'b1;
            burst_ready_n_o <= 1'b1;
            while (bus_req_i === 1'b1) @(posedge clk_sys_i);
        end
    end
endmodule

/* dclsc_line_state_bench.sv */
// self-checking bench for the line state control with its bus agent
`timescale 1ns/1ns
module dclsc_line_state_bench;
    import dclsc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic op_valid = 1'b0;
    dclsc_op_t op_kind = OP_READ;
    logic [2:0] op_line = 3'h0;
    logic inquiry_invalidate = 1'b0;
    logic pwt = 1'b0;
    logic pol = 1'b0;
    logic wo = 1'b0;
    logic [3:0] dly = 4'h0;
    logic op_ready, op_done, bus_req, pol_pin, na_n, burst_ready_n;
    dclsc_bus_t bus_kind;
    dclsc_bus_t seen_kind = BUS_NONE;
    logic [2:0] bus_line, seen_line;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, d;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    dclsc_line_state i_dut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .op_valid_i(op_valid),
        .op_kind_i(op_kind),
        .op_line_i(op_line),
        .inquiry_invalidate_i(inquiry_invalidate),
        .page_write_through_bit_i(pwt),
        .op_ready_o(op_ready),
        .op_done_o(op_done),
        .policy_select_pin_i(pol_pin),
        .next_address_request_n_i(na_n),
        .burst_ready_n_i(burst_ready_n),
        .bus_req_o(bus_req),
        .bus_kind_o(bus_kind),
        .bus_line_o(bus_line),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata)
    );

    dclsc_bus_agent i_agent (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .bus_req_i(bus_req),
        .bus_kind_i(bus_kind),
        .pol_i(pol),
        .write_once_i(wo),
        .delay_i(dly),
        .policy_select_pin_o(pol_pin),
        .next_address_request_n_o(na_n),
        .burst_ready_n_o(burst_ready_n)
    );

    // remembers which bus cycle, if any, the last operation opened
    always @(posedge clk_sys_i) begin
        if (bus_req === 1'b1) begin
            seen_kind <= bus_kind;
            seen_line <= bus_line;
        end
    end

    task automatic results;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // flags: bit3 invalidate, bit2 page write-through, bit1 pin level, bit0 write-once
    task automatic step(input dclsc_op_t k, input logic [2:0] ln, input logic [3:0] f,
                        input dclsc_mesi_t st, input dclsc_bus_t bk);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        seen_kind = BUS_NONE;
        @(posedge clk_sys_i);
        pol <= f[1];
        wo <= f[0];
        // alternate a prompt and a slow far side
        dly <= (dly == 4'h0) ? 4'h5 : 4'h0;
        op_valid <= 1'b1;
        op_kind <= k;
        op_line <= ln;
        inquiry_invalidate <= f[3];
        pwt <= f[2];
        @(posedge clk_sys_i);
        op_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (op_done !== 1'b1 && n < 100);
        check({31'h0, n < 100}, 32'h1);
        check({30'h0, bus_kind}, 32'h0);
        check({30'h0, seen_kind}, {30'h0, bk});
        if (bk != BUS_NONE) check({29'h0, seen_line}, {29'h0, ln});
        reg_write(8'h08, {29'h0, ln});
        reg_read(8'h0C);
        check(d, {30'h0, st});
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        reg_read(8'h00);
        check(d, 32'h0);
        for (int i = 0; i < 8; i++) begin
            reg_write(8'h08, 32'(i));
            reg_read(8'h0C);
            check(d, 32'h0);
        end
        reg_read(8'h20);
        check(d, 32'h0);
        step(OP_READ, 3'h0, 4'h2, DCLSC_E, BUS_FILL);
        step(OP_READ, 3'h1, 4'h0, DCLSC_S, BUS_FILL);
        step(OP_READ, 3'h0, 4'h0, DCLSC_E, BUS_NONE);
        step(OP_WRITE, 3'h0, 4'h0, DCLSC_M, BUS_NONE);
        step(OP_WRITE, 3'h0, 4'h2, DCLSC_M, BUS_NONE);
        step(OP_READ, 3'h0, 4'h0, DCLSC_M, BUS_NONE);
        step(OP_READ, 3'h1, 4'h2, DCLSC_S, BUS_NONE);
        step(OP_WRITE, 3'h1, 4'h0, DCLSC_S, BUS_WRITE);
        step(OP_WRITE, 3'h1, 4'h2, DCLSC_E, BUS_WRITE);
        step(OP_WRITE, 3'h2, 4'h2, DCLSC_I, BUS_WRITE);
        step(OP_READ, 3'h2, 4'h6, DCLSC_S, BUS_FILL);
        step(OP_WRITE, 3'h1, 4'h4, DCLSC_E, BUS_WRITE);
        step(OP_INQUIRY, 3'h0, 4'h0, DCLSC_S, BUS_WBACK);
        step(OP_INQUIRY, 3'h1, 4'h0, DCLSC_S, BUS_NONE);
        step(OP_INQUIRY, 3'h3, 4'h0, DCLSC_I, BUS_NONE);
        step(OP_INQUIRY, 3'h1, 4'h8, DCLSC_I, BUS_NONE);
        step(OP_INQUIRY, 3'h0, 4'h8, DCLSC_I, BUS_NONE);
        step(OP_READ, 3'h3, 4'h2, DCLSC_E, BUS_FILL);
        step(OP_WRITE, 3'h3, 4'h0, DCLSC_M, BUS_NONE);
        step(OP_INQUIRY, 3'h3, 4'h8, DCLSC_I, BUS_WBACK);
        step(OP_READ, 3'h4, 4'h2, DCLSC_E, BUS_FILL);
        step(OP_WRITE, 3'h4, 4'h0, DCLSC_M, BUS_NONE);
        step(OP_REPLACE, 3'h4, 4'h0, DCLSC_I, BUS_WBACK);
        step(OP_REPLACE, 3'h2, 4'h0, DCLSC_I, BUS_NONE);
        step(OP_READ, 3'h5, 4'h1, DCLSC_S, BUS_FILL);
        step(OP_WRITE, 3'h5, 4'h1, DCLSC_E, BUS_WRITE);
        step(OP_WRITE, 3'h5, 4'h1, DCLSC_M, BUS_NONE);
        reg_write(8'h00, 32'h1);
        step(OP_READ, 3'h6, 4'h2, DCLSC_S, BUS_FILL);
        reg_write(8'h0C, 32'h3);
        reg_read(8'h0C);
        check(d, 32'h1);
        reg_read(8'h00);
        check(d, 32'h1);
        results();
    end

    // the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        results();
    end
endmodule
